// [include/spc_pkg.sv]
// spc_pkg: constants for the sleep and power controller
// assumes a 20 MHz aclk and a 32-bit axi4-lite register bus
package spc_pkg;
  // --------------------------------------------------------------
  // register map (byte addresses)
  // --------------------------------------------------------------
  localparam logic [7:0] ADDR_MCU_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PWR_RED    = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  // mcu_control_register fields
  localparam int BIT_BOD_OFF    = 7;
  localparam int BIT_SLEEP_ARM  = 5;
  localparam int BIT_MODE_HI    = 4;
  localparam int BIT_MODE_LO    = 3;
  localparam int BIT_BOD_UNLOCK = 2;
  localparam logic [7:0] MCU_CTRL_RESET = 8'h00;
  localparam logic [7:0] MCU_CTRL_WMASK = 8'h7F; // bod bit via sequence only
  // power_reduction_register: low four bits writable
  localparam logic [7:0] PWR_RED_RESET  = 8'h00;
  localparam logic [7:0] PWR_RED_WMASK  = 8'h0F;
  localparam int PR_TIM1 = 3;
  localparam int PR_TIM0 = 2;
  localparam int PR_USI  = 1;
  localparam int PR_ADC  = 0;
  // sleep modes
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_ADC  = 2'h1;
  localparam logic [1:0] MODE_PDN  = 2'h2;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam logic [3:0] WAKE_HALT_CYC   = 4'h4; // halt after start-up
  localparam logic [3:0] UNLOCK_WIN_CYC  = 4'h4; // bod unlock window
  localparam logic [3:0] BOD_DELAY_CYC   = 4'h3; // bod bit becomes active
  localparam logic [3:0] BOD_ACTIVE_CYC  = 4'h3; // bod bit active span
  localparam logic [15:0] STARTUP_CYC    = 16'h0010;
  localparam logic [15:0] RESET_WAKE_CYC = 16'h0040;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SPC_RUN   = 2'b00,
    SPC_SLEEP = 2'b01,
    SPC_START = 2'b11,
    SPC_HALT  = 2'b10
  } spc_state_t;
endpackage

// [logic/spc_ctrl.sv]
// spc_ctrl: sleep mode, clock gating, bod sleep-off and module clock stop
// assumes core strobes and wake sources are synchronous to aclk
//
// How it works
// - sleep only if arm bit set when sleep instruction executes
// - mode field 00 idle, 01 adc noise reduction, 10 power-down
// - interrupt wake holds core four cycles past start-up, then resumes
// - core stays halted, never reset, so registers and sram are kept
// - reset during sleep wakes to reset vector, not the next instruction
// - idle stops core and flash clocks, keeps io, adc and oscillator
// - idle wakes on any enabled interrupt
// - entering idle or adc mode with adc enabled starts a conversion
// - adc mode stops io, core and flash clocks, keeps adc clock
// - adc mode wakes on adc done, resets, self-programming, ext0 level, pin change
// - power-down stops oscillator and every generated clock
// - power-down wakes on resets, watchdog, ext0 level, pin change
// - bod off on entering power-down with sleep-off set, on at wake
// - wake delay after bod-off sleep equals the reset wake delay
// - bod sleep-off control is bit 7, resets to zero
// - sleep-off control set only by timed sequence, plain writes ignored
// - write both bits one, then within four cycles bod one, unlock zero
// - sleep-off active three cycles after set, clears three cycles later
// - module stop bit gates its clock and blocks its register access
// - clearing the bit restarts the clock with state untouched
// - module stop acts in active and idle, and for the adc also in adc mode; other clocks already stopped in deeper modes
// - input buffers off when io and adc clocks both stop, wake pins kept
// - adc enable untouched by sleep; re-enable requests extended conversion
// - comparator forced off in modes deeper than adc noise reduction
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module spc_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // core side
  input  wire logic        sleep_instr,
  input  wire logic        sys_reset_req,
  input  wire logic        adc_enabled,
  // wake sources
  input  wire logic        irq_ext0_level,
  input  wire logic        irq_ext0_edge,
  input  wire logic        irq_pin_change,
  input  wire logic        irq_selfprog_ready,
  input  wire logic        irq_adc_done,
  input  wire logic        irq_other_io,
  input  wire logic        irq_watchdog,
  input  wire logic        rst_wake,
  // clock and power controls
  output logic             core_clk_en,
  output logic             flash_clk_en,
  output logic             io_clk_en,
  output logic             adc_clk_en,
  output logic             osc_en,
  output logic             bod_en,
  output logic             core_halt,
  output logic             take_irq,
  output logic             restart_reset,
  output logic             adc_start,
  output logic             adc_extended,
  output logic             comparator_force_off,
  output logic             input_buf_en,
  output logic [3:0]       module_clk_en,
  output logic [3:0]       module_access_en
);

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  typedef struct packed {
    spc_pkg::spc_state_t st;
    logic [1:0]  mode;
    logic        bod_off_sleep;
    logic        wake_reset;
    logic [15:0] cnt;
    logic [7:0]  mcu_ctrl;
    logic [7:0]  pwr_red;
    logic [3:0]  unlock_cnt;
    logic [3:0]  bod_cnt;
    logic        bod_active;
    logic        adc_start;
    logic        take_irq;
    logic        restart;
    logic        adc_was_on;
    logic        adc_ext;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic        rerr;
    logic        werr;
  } spc_regs_t;

  spc_regs_t r_r;
  spc_regs_t r_nxt;

  // wake permitted per mode
  function automatic logic wake_ok(input logic [1:0] m, input logic lvl, input logic edg,
                                   input logic pc, input logic self_programming_operation, input logic adc,
                                   input logic oth, input logic wdt);
    logic w;
    w = 1'b0;
    case (m)
      spc_pkg::MODE_IDLE: w = lvl | edg | pc | self_programming_operation | adc | oth | wdt;
      spc_pkg::MODE_ADC:  w = lvl | pc | self_programming_operation | adc | wdt;
      spc_pkg::MODE_PDN:  w = lvl | pc | wdt;
      default:            w = 1'b0;
    endcase
    return w;
  endfunction

  logic wake_irq;
  logic aw_go;
  logic ar_go;
  logic [7:0] wbyte;
  logic asleep;

  assign wake_irq = wake_ok(r_r.mode, irq_ext0_level, irq_ext0_edge, irq_pin_change,
                            irq_selfprog_ready, irq_adc_done, irq_other_io, irq_watchdog);
  // write taken only with both channels present; ready mirrors that
  assign aw_go = s_axi_awvalid & s_axi_wvalid & ~r_r.bvalid & clk_en;
  assign ar_go = s_axi_arvalid & ~r_r.rvalid & clk_en;
  assign wbyte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
  assign asleep = (r_r.st == spc_pkg::SPC_SLEEP);

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    r_nxt.adc_start = 1'b0;
    r_nxt.take_irq  = 1'b0;
    r_nxt.restart   = 1'b0;
    // bod sleep-off timing
    if (r_r.unlock_cnt != 4'h0) begin
      r_nxt.unlock_cnt = r_r.unlock_cnt - 4'h1;
    end
    if (r_r.unlock_cnt == 4'h1) begin
      r_nxt.mcu_ctrl[spc_pkg::BIT_BOD_UNLOCK] = 1'b0;
    end
    if (r_r.bod_cnt != 4'h0) begin
      r_nxt.bod_cnt = r_r.bod_cnt - 4'h1;
      if (r_r.bod_cnt == spc_pkg::BOD_ACTIVE_CYC + 4'h1) begin
        r_nxt.bod_active = 1'b1;
      end
      if (r_r.bod_cnt == 4'h1) begin
        r_nxt.bod_active = 1'b0;
        r_nxt.mcu_ctrl[spc_pkg::BIT_BOD_OFF] = 1'b0;
      end
    end
    // register writes
    if (aw_go) begin
      r_nxt.bvalid = 1'b1;
      r_nxt.werr = 1'b0;
      case (s_axi_awaddr)
        spc_pkg::ADDR_MCU_CTRL: if (s_axi_wstrb[0]) begin
          r_nxt.mcu_ctrl = (r_r.mcu_ctrl & ~spc_pkg::MCU_CTRL_WMASK)
                         | (wbyte & spc_pkg::MCU_CTRL_WMASK);
          if (wbyte[spc_pkg::BIT_BOD_OFF] && wbyte[spc_pkg::BIT_BOD_UNLOCK]) begin
            r_nxt.unlock_cnt = spc_pkg::UNLOCK_WIN_CYC;
          end else if (wbyte[spc_pkg::BIT_BOD_OFF] && r_r.unlock_cnt != 4'h0) begin
            r_nxt.mcu_ctrl[spc_pkg::BIT_BOD_OFF] = 1'b1;
            r_nxt.mcu_ctrl[spc_pkg::BIT_BOD_UNLOCK] = 1'b0;
            r_nxt.unlock_cnt = 4'h0;
            r_nxt.bod_cnt = spc_pkg::BOD_DELAY_CYC + spc_pkg::BOD_ACTIVE_CYC;
          end else begin
            r_nxt.mcu_ctrl[spc_pkg::BIT_BOD_UNLOCK] = 1'b0; // plain write: no effect
            r_nxt.unlock_cnt = 4'h0;
          end
        end
        spc_pkg::ADDR_PWR_RED: if (s_axi_wstrb[0]) begin
          r_nxt.pwr_red = wbyte & spc_pkg::PWR_RED_WMASK;
        end
        spc_pkg::ADDR_STATUS: ;
        default: r_nxt.werr = 1'b1;
      endcase
    end else if (s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end
    // register reads
    if (ar_go) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rerr = 1'b0;
      case (s_axi_araddr)
        spc_pkg::ADDR_MCU_CTRL: r_nxt.rdata = {24'h000000, r_r.mcu_ctrl};
        spc_pkg::ADDR_PWR_RED:  r_nxt.rdata = {24'h000000, r_r.pwr_red};
        spc_pkg::ADDR_STATUS:   r_nxt.rdata = {27'h0000000, r_r.bod_active,
                                               r_r.mode, r_r.st};
        default: begin
          r_nxt.rdata = 32'h00000000;
          r_nxt.rerr = 1'b1;
        end
      endcase
    end else if (s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    // adc re-enable tracking
    r_nxt.adc_was_on = adc_enabled;
    if (adc_enabled && !r_r.adc_was_on) begin
      r_nxt.adc_ext = 1'b1;
    end else if (r_r.adc_start) begin
      r_nxt.adc_ext = 1'b0;
    end
    // sleep sequencer
    case (r_r.st)
      spc_pkg::SPC_RUN: begin
        if (sleep_instr && r_r.mcu_ctrl[spc_pkg::BIT_SLEEP_ARM] &&
            r_r.mcu_ctrl[spc_pkg::BIT_MODE_HI:spc_pkg::BIT_MODE_LO] != 2'h3) begin
          r_nxt.st = spc_pkg::SPC_SLEEP;
          r_nxt.mode = r_r.mcu_ctrl[spc_pkg::BIT_MODE_HI:spc_pkg::BIT_MODE_LO];
          r_nxt.bod_off_sleep = r_r.bod_active &&
            r_r.mcu_ctrl[spc_pkg::BIT_MODE_HI:spc_pkg::BIT_MODE_LO] == spc_pkg::MODE_PDN;
          r_nxt.adc_start = adc_enabled &&
            r_r.mcu_ctrl[spc_pkg::BIT_MODE_HI:spc_pkg::BIT_MODE_LO] != spc_pkg::MODE_PDN;
        end
      end
      spc_pkg::SPC_SLEEP: begin
        if (rst_wake || wake_irq) begin
          r_nxt.st = spc_pkg::SPC_START;
          r_nxt.wake_reset = rst_wake;
          // bod restart or reset wake uses the longer delay
          r_nxt.cnt = (r_r.bod_off_sleep || rst_wake) ? spc_pkg::RESET_WAKE_CYC
                                                      : spc_pkg::STARTUP_CYC;
        end
      end
      spc_pkg::SPC_START: begin
        r_nxt.bod_off_sleep = 1'b0;
        if (r_r.cnt <= 16'h0001) begin
          r_nxt.st = spc_pkg::SPC_HALT;
          r_nxt.cnt = {12'h000, spc_pkg::WAKE_HALT_CYC};
        end else begin
          r_nxt.cnt = r_r.cnt - 16'h0001;
        end
      end
      spc_pkg::SPC_HALT: begin
        if (r_r.cnt <= 16'h0001) begin
          r_nxt.st = spc_pkg::SPC_RUN;
          r_nxt.take_irq = ~r_r.wake_reset;
          r_nxt.restart  = r_r.wake_reset;
          r_nxt.wake_reset = 1'b0;
        end else begin
          r_nxt.cnt = r_r.cnt - 16'h0001;
        end
      end
      default: r_nxt.st = spc_pkg::SPC_RUN;
    endcase
  end

  // --------------------------------------------------------------
  // state register; clk_en freezes everything
  // --------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r <= '0; // reset values are all zero
    end else if (clk_en) begin
      r_r <= r_nxt;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // core never reset by sleep, so register file and sram survive
  assign core_clk_en  = ~asleep & (r_r.st == spc_pkg::SPC_RUN);
  assign flash_clk_en = core_clk_en;
  assign io_clk_en    = ~(asleep && r_r.mode != spc_pkg::MODE_IDLE);
  assign adc_clk_en   = ~(asleep && r_r.mode == spc_pkg::MODE_PDN);
  assign osc_en       = adc_clk_en;
  assign bod_en       = ~(asleep && r_r.bod_off_sleep);
  assign core_halt    = ~core_clk_en;
  assign take_irq     = r_r.take_irq;
  assign restart_reset = r_r.restart | sys_reset_req;
  assign adc_start    = r_r.adc_start;
  assign adc_extended = r_r.adc_ext;
  assign comparator_force_off = asleep && r_r.mode == spc_pkg::MODE_PDN;
  assign input_buf_en = ~(asleep && r_r.mode == spc_pkg::MODE_PDN);
  // module gating only meaningful while io/adc clocks run
  assign module_clk_en = ~r_r.pwr_red[3:0] & {io_clk_en, io_clk_en, io_clk_en, adc_clk_en};
  assign module_access_en = ~r_r.pwr_red[3:0];

  assign s_axi_awready = aw_go;
  assign s_axi_wready  = aw_go;
  assign s_axi_bvalid  = r_r.bvalid;
  assign s_axi_bresp   = r_r.werr ? spc_pkg::RESP_SLVERR : spc_pkg::RESP_OKAY;
  assign s_axi_arready = ar_go;
  assign s_axi_rvalid  = r_r.rvalid;
  assign s_axi_rdata   = r_r.rdata;
  assign s_axi_rresp   = r_r.rerr ? spc_pkg::RESP_SLVERR : spc_pkg::RESP_OKAY;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_arm;
    @(posedge aclk) disable iff (!aresetn)
    (r_r.st == spc_pkg::SPC_RUN && clk_en && sleep_instr &&
     !r_r.mcu_ctrl[spc_pkg::BIT_SLEEP_ARM]) |=> r_r.st == spc_pkg::SPC_RUN;
  endproperty
  a_arm: assert property (p_arm) else $error("sleep entered without arm");
  property p_rsv;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && r_r.mcu_ctrl[spc_pkg::BIT_MODE_HI:spc_pkg::BIT_MODE_LO] == 2'h3 &&
     r_r.st == spc_pkg::SPC_RUN) |=> !asleep;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved mode slept");
  property p_idle;
    @(posedge aclk) disable iff (!aresetn)
    (asleep && r_r.mode == spc_pkg::MODE_IDLE) |-> (!core_clk_en && io_clk_en && osc_en);
  endproperty
  a_idle: assert property (p_idle) else $error("idle clocks wrong");
  property p_adcm;
    @(posedge aclk) disable iff (!aresetn)
    (asleep && r_r.mode == spc_pkg::MODE_ADC) |-> (!io_clk_en && adc_clk_en);
  endproperty
  a_adcm: assert property (p_adcm) else $error("adc mode clocks wrong");
  property p_pdn;
    @(posedge aclk) disable iff (!aresetn)
    (asleep && r_r.mode == spc_pkg::MODE_PDN) |-> (!osc_en && !adc_clk_en && !input_buf_en);
  endproperty
  a_pdn: assert property (p_pdn) else $error("power-down clocks running");
  property p_pdn_wake;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && asleep && r_r.mode == spc_pkg::MODE_PDN && !rst_wake && irq_other_io &&
     !irq_ext0_level && !irq_pin_change && !irq_watchdog) |=> asleep;
  endproperty
  a_pdn_wake: assert property (p_pdn_wake) else $error("power-down woke on io");
  property p_halt;
    @(posedge aclk) disable iff (!aresetn)
    ($rose(r_r.st == spc_pkg::SPC_HALT) && clk_en) |-> ##1 core_halt ##1 core_halt;
  endproperty
  a_halt: assert property (p_halt) else $error("halt too short");
  property p_bodlife;
    @(posedge aclk) disable iff (!aresetn)
    $rose(r_r.bod_active) |-> r_r.bod_active [*2];
  endproperty
  a_bodlife: assert property (p_bodlife) else $error("bod active too short");
  property p_modstop;
    @(posedge aclk) disable iff (!aresetn)
    r_r.pwr_red[spc_pkg::PR_USI] |-> !module_clk_en[spc_pkg::PR_USI];
  endproperty
  a_modstop: assert property (p_modstop) else $error("stopped module clocked");
endmodule

// [dv/spc_wake_model.sv]
// spc_wake_model: interrupt sources standing beside the sleep controller
// assumes the bench pulses raise for one cycle right after a rising edge
`timescale 1ns/10ps
module spc_wake_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [6:0] raise,
  input  wire logic       take_irq,
  input  wire logic       restart_reset,
  output logic      [6:0] irq_lvl
);
  // -------------------------------------------------------------
  // level sources
  // -------------------------------------------------------------
  // held until handler entry or restart, else a slow wake-up could miss it
  always_ff @(posedge aclk) begin
    if (!aresetn || take_irq || restart_reset) begin
      irq_lvl <= 7'h00;
    end else begin
      irq_lvl <= irq_lvl | raise;
    end
  end
endmodule

// [dv/sleep_mode_power_controller_tb.sv]
// sleep_mode_power_controller_tb: self-checking bench for spc_ctrl
// assumes spc_pkg is compiled first and spc_wake_model is present
`timescale 1ns/10ps
module sleep_mode_power_controller_tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_instr;
  logic        awready, wready, bvalid, arready, rvalid, rst_wake, adc_en, bod_en;
  logic        core_ce, flash_ce, io_ce, adc_ce, osc_en, halt, take_irq, rst_vec;
  logic        adc_start, adc_ext, cmp_off, ibuf_en, ce, sys_rst;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, mclk, macc, gate;
  logic [1:0]  bresp, rresp;
  logic [6:0]  raise, irq;
  logic [6:0]  okm [3] = '{7'h7F, 7'h5D, 7'h51};
  int          err_total, comparisons, n_irq, n_rst, n_adc, m, s;

  spc_ctrl i_spc_ctrl (.aclk(aclk), .aresetn(aresetn), .clk_en(ce), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep_instr(sleep_instr), .sys_reset_req(sys_rst),
    .adc_enabled(adc_en), .irq_ext0_level(irq[6]), .irq_ext0_edge(irq[5]),
    .irq_pin_change(irq[4]), .irq_selfprog_ready(irq[3]), .irq_adc_done(irq[2]),
    .irq_other_io(irq[1]), .irq_watchdog(irq[0]), .rst_wake(rst_wake), .core_clk_en(core_ce),
    .flash_clk_en(flash_ce), .io_clk_en(io_ce), .adc_clk_en(adc_ce), .osc_en(osc_en),
    .bod_en(bod_en), .core_halt(halt), .take_irq(take_irq), .restart_reset(rst_vec),
    .adc_start(adc_start), .adc_extended(adc_ext), .comparator_force_off(cmp_off),
    .input_buf_en(ibuf_en), .module_clk_en(mclk), .module_access_en(macc));

  spc_wake_model i_spc_wake_model (.aclk(aclk), .aresetn(aresetn), .raise(raise),
    .take_irq(take_irq), .restart_reset(rst_vec), .irq_lvl(irq));

  // -------------------------------------------------------------
  // clock and pulse counters
  // -------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // registered pulses, counted so no check hangs on their exact cycle
  always @(posedge aclk) begin
    if (take_irq === 1'b1) n_irq++;
    if (rst_vec === 1'b1) n_rst++;
    if (adc_start === 1'b1) n_adc++;
  end

  // -------------------------------------------------------------
  // checking and closing
  // -------------------------------------------------------------
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function logic sig(input int w);
    case (w)
      0: return awready && wready;
      1: return bvalid;
      2: return arready;
      default: return rvalid;
    endcase
  endfunction

  // bounded wait on a bus handshake, sampled mid-cycle
  task await(input int w);
    int k;
    @(negedge aclk);
    for (k = 0; sig(w) !== 1'b1; k++) begin
      if (k > 200) begin
        err_total++;
        $display("CHECK FAILED bus wait expected answer seen timeout");
        conclude;
      end
      @(negedge aclk);
    end
  endtask

  // -------------------------------------------------------------
  // axi4-lite master, entered right after a rising edge
  // -------------------------------------------------------------
  task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    await(0);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    await(1);
    chk("bresp", bresp, er);
    // bready stays high: lowering it here would clash with the next call's raise
    @(posedge aclk);
  endtask

  task axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    await(2);
    @(posedge aclk);
    arvalid <= 1'b0;
    await(3);
    chk("rdata", rdata, ed);
    chk("rresp", rresp, er);
    // rready stays high for the same reason as bready
    @(posedge aclk);
  endtask

  // sleep instruction; ends mid-cycle with the new state settled
  task go_sleep;
    sleep_instr <= 1'b1;
    @(posedge aclk);
    sleep_instr <= 1'b0;
    repeat (3) @(negedge aclk);
  endtask

  // wake by source or reset, measuring cycles to handler or restart
  task wake(input int src, input int lo, input bit by_rst);
    int k, i0, r0;
    i0 = n_irq;
    r0 = n_rst;
    @(posedge aclk);
    if (by_rst) rst_wake <= 1'b1;
    else raise <= 7'h01 << src;
    @(posedge aclk);
    raise <= 7'h00;
    for (k = 1; n_irq == i0 && n_rst == r0; k++) begin
      if (k > 400) begin
        err_total++;
        $display("CHECK FAILED wake expected pulse seen timeout");
        conclude;
      end
      @(negedge aclk);
    end
    @(posedge aclk);
    rst_wake <= 1'b0;
    // bench adds four cycles of latency, one less when reset drives the pin directly
    chk("wake delay", k, lo + 4 - by_rst);
    chk("restart pulses", n_rst - r0, by_rst);
    chk("handler pulses", n_irq - i0, !by_rst);
  endtask

  function int pick(input logic [6:0] msk);
    int p;
    do p = $urandom % 7; while (!msk[p]);
    return p;
  endfunction

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_instr, rst_wake, adc_en} = '0;
    {awaddr, araddr, wdata, wstrb, raise} = '0;
    {ce, sys_rst} = 2'b10;
    void'($urandom(35209));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axr(spc_pkg::ADDR_MCU_CTRL, 32'h0, spc_pkg::RESP_OKAY);
    axr(spc_pkg::ADDR_PWR_RED, 32'h0, spc_pkg::RESP_OKAY);
    axr(spc_pkg::ADDR_STATUS, 32'h0, spc_pkg::RESP_OKAY);
    axr(8'h0C, 32'h0, spc_pkg::RESP_SLVERR);
    axw(8'h0C, 32'h0, spc_pkg::RESP_SLVERR);
    // core reset request passes straight through to the restart output
    sys_rst <= 1'b1;
    @(negedge aclk);
    chk("reset request passed", rst_vec, 1'b1);
    @(posedge aclk);
    sys_rst <= 1'b0;
    $display("test registers done");
    // module clock stop and restart
    gate = 4'($urandom) | 4'h1;
    axw(spc_pkg::ADDR_PWR_RED, {28'h0, gate}, spc_pkg::RESP_OKAY);
    axr(spc_pkg::ADDR_PWR_RED, {28'h0, gate}, spc_pkg::RESP_OKAY);
    chk("module clocks", {mclk, macc}, {~gate, ~gate});
    axw(spc_pkg::ADDR_PWR_RED, 32'h0, spc_pkg::RESP_OKAY);
    chk("module clocks back", {mclk, macc}, 8'hFF);
    $display("test power reduction done");
    // no arm bit, then reserved mode code
    axw(spc_pkg::ADDR_MCU_CTRL, 32'h10, spc_pkg::RESP_OKAY);
    go_sleep;
    chk("unarmed clocks", {core_ce, flash_ce, io_ce, adc_ce, osc_en}, 5'h1F);
    @(posedge aclk);
    axw(spc_pkg::ADDR_MCU_CTRL, 32'h38, spc_pkg::RESP_OKAY);
    go_sleep;
    chk("reserved mode clocks", {core_ce, osc_en, halt}, 3'b110);
    @(posedge aclk);
    $display("test no-sleep done");
    adc_en <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("extended conversion", adc_ext, 1'b1);
    // every mode; a refused source in adc and power-down modes only, then an accepted one
    for (m = 0; m < 3; m++) begin
      gate = 4'($urandom);
      axw(spc_pkg::ADDR_PWR_RED, {28'h0, gate}, spc_pkg::RESP_OKAY);
      axw(spc_pkg::ADDR_MCU_CTRL, 32'h20 | (m << 3), spc_pkg::RESP_OKAY);
      // enable low freezes all state, so this sleep pulse is lost
      if (m == 0) begin
        ce <= 1'b0;
        go_sleep;
        chk("enable low freezes", core_ce, 1'b1);
        @(posedge aclk);
        ce <= 1'b1;
      end
      s = n_adc;
      go_sleep;
      chk("sleep clocks", {core_ce, flash_ce, io_ce, adc_ce, osc_en},
          {2'b00, m == 0, m != 2, m != 2});
      chk("buffers and comparator", {ibuf_en, cmp_off}, {m != 2, m == 2});
      chk("conversion start", n_adc - s, m != 2);
      if (m == 0) chk("idle module clocks", mclk, 4'(~gate));
      if (m > 0) begin
        @(posedge aclk);
        raise <= 7'h01 << pick(~okm[m]);
        @(posedge aclk);
        raise <= 7'h00;
        repeat (10) @(negedge aclk);
        chk("refused source", core_ce, 1'b0);
      end
      wake(pick(okm[m]), spc_pkg::STARTUP_CYC + spc_pkg::WAKE_HALT_CYC, 0);
      chk("awake clocks", {core_ce, halt}, 2'b10);
      axr(spc_pkg::ADDR_MCU_CTRL, 32'h20 | (m << 3), spc_pkg::RESP_OKAY);
      $display("test mode %0d done", m);
    end
    // reset while asleep restarts from the vector
    axw(spc_pkg::ADDR_MCU_CTRL, 32'h30, spc_pkg::RESP_OKAY);
    go_sleep;
    wake(0, spc_pkg::RESET_WAKE_CYC + spc_pkg::WAKE_HALT_CYC, 1);
    $display("test reset wake done");
    // sleep-off bit: plain write, late second write, then the real sequence
    axw(spc_pkg::ADDR_MCU_CTRL, 32'h80, spc_pkg::RESP_OKAY);
    axr(spc_pkg::ADDR_MCU_CTRL, 32'h0, spc_pkg::RESP_OKAY);
    axw(spc_pkg::ADDR_MCU_CTRL, 32'h84, spc_pkg::RESP_OKAY);
    repeat (6) @(posedge aclk);
    axw(spc_pkg::ADDR_MCU_CTRL, 32'h80, spc_pkg::RESP_OKAY);
    axr(spc_pkg::ADDR_MCU_CTRL, 32'h0, spc_pkg::RESP_OKAY);
    axw(spc_pkg::ADDR_MCU_CTRL, 32'h84, spc_pkg::RESP_OKAY);
    axw(spc_pkg::ADDR_MCU_CTRL, 32'hB0, spc_pkg::RESP_OKAY);
    // sleep-off is seen by the sequencer from the fourth edge after the set
    repeat (2) @(posedge aclk);
    go_sleep;
    chk("detector off asleep", bod_en, 1'b0);
    wake(6, spc_pkg::RESET_WAKE_CYC + spc_pkg::WAKE_HALT_CYC, 0);
    chk("detector back on", bod_en, 1'b1);
    axr(spc_pkg::ADDR_MCU_CTRL, 32'h30, spc_pkg::RESP_OKAY);
    $display("test detector sleep-off done");
    conclude;
  end
endmodule
